// file: src/bmsd_top.v
// Function
// - sample straps after reset, select one mode
// - flash strap high: branch to flash entry
// - flash low, eeprom high: spi eeprom load
// - pattern 0011: async serial port load
// - pattern 0010: jump to ram entry
// - pattern 0001: jump to otp entry
// - all low: parallel load from port
// - flash strap pulled up, others not
// - memory entry modes fetch no external code
// - microprocessor mode high: no strap decoding
`timescale 1ns/1ps
`default_nettype none
`include "bmsd_map.vh"
module bmsd_top (
	input  wire        clk,
	input  wire        rst,
	input  wire        strap_flash_select,
	input  wire        strap_eeprom_select,
	input  wire        strap_third,
	input  wire        strap_fourth,
	input  wire        microprocessor_mode_pin,
	output reg  [2:0]  boot_mode,
	output reg  [21:0] entry_addr,
	output reg         mode_valid,
	output reg         load_eeprom,
	output reg         load_uart,
	output reg         load_parallel,
	output reg         ext_fetch_allowed,
	output reg         boot_rom_enable,
	output reg  [3:0]  strap_pullup_en
);
	// sequencer states; the settle count lets both synchroniser stages fill
	localparam [1:0] ST_SYNC   = `BMSD_ST_SYNC;
	localparam [1:0] ST_SAMPLE = `BMSD_ST_SAMPLE;
	localparam [1:0] ST_DONE   = `BMSD_ST_DONE;
	// width of the synchronised pin vector: four straps plus the mode pin
	localparam       PIN_W     = `BMSD_PIN_W;
	// pull-up enables, ordered {flash, eeprom, third, fourth}
	localparam [3:0] PULLUP_EN = {`BMSD_PULLUP_FLASH, `BMSD_PULLUP_OTHER,
		`BMSD_PULLUP_OTHER, `BMSD_PULLUP_OTHER};

	// synchronised pins and sequencer state
	wire [PIN_W-1:0] pins_s;
	reg  [1:0]       state_q;
	reg  [1:0]       state_d;
	reg  [1:0]       wait_q;
	reg  [1:0]       wait_d;

	// sample strobe and next values of the decision outputs
	reg              sample_now;
	reg  [2:0]       mode_d;
	reg  [21:0]      entry_addr_d;
	reg              load_eeprom_d;
	reg              load_uart_d;
	reg              load_parallel_d;
	reg              ext_fetch_d;
	reg              rom_enable_d;

	// straps and mode pin come from the board, so synchronise them;
	// the first stage may go metastable and is read by nothing else
	bmsd_sync #(
		.W(PIN_W)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({microprocessor_mode_pin, strap_flash_select,
			strap_eeprom_select, strap_third, strap_fourth}),
		.sync_out (pins_s)
	);

	// priority decode of the four straps plus mode pin:
	// mode pin beats everything, then the flash strap, then the eeprom strap;
	// only when both are low do the third and fourth straps count
	function [2:0] decode_mode;
		input [PIN_W-1:0] p;
		begin
			if (p[`BMSD_BIT_MPMODE])
				decode_mode = `BMSD_MODE_EXTERNAL;
			else if (p[`BMSD_BIT_FLASH])
				decode_mode = `BMSD_MODE_FLASH;
			else if (p[`BMSD_BIT_EEPROM])
				decode_mode = `BMSD_MODE_EEPROM;
			else if (p[`BMSD_BIT_THIRD] && p[`BMSD_BIT_FOURTH])
				decode_mode = `BMSD_MODE_UART;
			else if (p[`BMSD_BIT_THIRD])
				decode_mode = `BMSD_MODE_RAM;
			else if (p[`BMSD_BIT_FOURTH])
				decode_mode = `BMSD_MODE_OTP;
			else
				decode_mode = `BMSD_MODE_PARALLEL;
		end
	endfunction

	// entry address for each jump mode; loader and external modes get zero,
	// since the loader or the external vectors decide where code starts
	function [21:0] mode_addr;
		input [2:0] m;
		begin
			case (m)
				`BMSD_MODE_FLASH: mode_addr = `BMSD_ADDR_FLASH;
				`BMSD_MODE_RAM:   mode_addr = `BMSD_ADDR_RAM;
				`BMSD_MODE_OTP:   mode_addr = `BMSD_ADDR_OTP;
				default:          mode_addr = `BMSD_ADDR_ZERO;
			endcase
		end
	endfunction

	// modes that pull code in from outside through a loader routine
	function is_loader;
		input [2:0] m;
		begin
			case (m)
				`BMSD_MODE_EEPROM:   is_loader = 1'b1;
				`BMSD_MODE_UART:     is_loader = 1'b1;
				`BMSD_MODE_PARALLEL: is_loader = 1'b1;
				default:             is_loader = 1'b0;
			endcase
		end
	endfunction

	// sequencer: wait for synchroniser, sample once, then hold
	always @* begin
		state_d = state_q;
		wait_d  = wait_q;
		mode_d  = boot_mode;
		case (state_q)
			ST_SYNC: begin
				// count the edges that fill both synchroniser stages
				wait_d = wait_q + 2'h1;
				if (wait_q == `BMSD_SETTLE - 2'h1)
					state_d = ST_SAMPLE;
			end
			ST_SAMPLE: begin
				mode_d  = decode_mode(pins_s);
				state_d = ST_DONE;
			end
			ST_DONE: begin
				// no way out short of reset, so later pin moves are ignored
				state_d = ST_DONE;
			end
			default: begin
				state_d = ST_SYNC;
			end
		endcase
	end

	// next values of the outputs, taken only on the sample cycle
	always @* begin
		sample_now      = (state_q == ST_SAMPLE);
		entry_addr_d    = mode_addr(mode_d);
		load_eeprom_d   = (mode_d == `BMSD_MODE_EEPROM);
		load_uart_d     = (mode_d == `BMSD_MODE_UART);
		load_parallel_d = (mode_d == `BMSD_MODE_PARALLEL);
		// jump modes and external mode load nothing through the loader
		ext_fetch_d     = is_loader(mode_d);
		rom_enable_d    = (mode_d != `BMSD_MODE_EXTERNAL);
	end

	// sequencer state and settle counter
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_SYNC;
			wait_q  <= 2'h0;
		end else begin
			state_q <= state_d;
			wait_q  <= wait_d;
		end
	end

	// decision registers: written once on the sample cycle, then frozen
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_mode  <= `BMSD_MODE_NONE;
			entry_addr <= `BMSD_ADDR_ZERO;
			mode_valid <= 1'b0;
		end else if (sample_now) begin
			boot_mode  <= mode_d;
			entry_addr <= entry_addr_d;
			mode_valid <= 1'b1;
		end
	end

	// loader requests; the decode yields one mode, so at most one is high
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			load_eeprom   <= 1'b0;
			load_uart     <= 1'b0;
			load_parallel <= 1'b0;
		end else if (sample_now) begin
			load_eeprom   <= load_eeprom_d;
			load_uart     <= load_uart_d;
			load_parallel <= load_parallel_d;
		end
	end

	// external fetch gate stays shut through reset and in every jump mode
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_fetch_allowed <= 1'b0;
		end else if (sample_now) begin
			ext_fetch_allowed <= ext_fetch_d;
		end
	end

	// boot rom stays mapped in reset; only the mode pin can unmap it
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_rom_enable <= 1'b1;
		end else if (sample_now) begin
			boot_rom_enable <= rom_enable_d;
		end
	end

	// pull-up enables never change; registered so the output leaves a flop
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_pullup_en <= PULLUP_EN;
		end else begin
			strap_pullup_en <= PULLUP_EN;
		end
	end
endmodule // bmsd_top
`default_nettype wire

// file: src/bmsd_map.vh
`ifndef BMSD_MAP_VH
`define BMSD_MAP_VH
// boot mode codes
`define BMSD_MODE_NONE     3'h0
`define BMSD_MODE_FLASH    3'h1
`define BMSD_MODE_EEPROM   3'h2
`define BMSD_MODE_UART     3'h3
`define BMSD_MODE_RAM      3'h4
`define BMSD_MODE_OTP      3'h5
`define BMSD_MODE_PARALLEL 3'h6
`define BMSD_MODE_EXTERNAL 3'h7
// entry addresses, 22 bits
`define BMSD_ADDR_FLASH    22'h3f7ff6
`define BMSD_ADDR_RAM      22'h3f8000
`define BMSD_ADDR_OTP      22'h3d7800
`define BMSD_ADDR_ZERO     22'h000000
// strap vector bit positions
`define BMSD_BIT_FLASH     3
`define BMSD_BIT_EEPROM    2
`define BMSD_BIT_THIRD     1
`define BMSD_BIT_FOURTH    0
// mode pin sits above the four straps in the synchronised vector
`define BMSD_BIT_MPMODE    4
`define BMSD_PIN_W         5
// pull-up enables per strap
`define BMSD_PULLUP_FLASH  1'h1
`define BMSD_PULLUP_OTHER  1'h0
// sequencer states
`define BMSD_ST_SYNC       2'h0
`define BMSD_ST_SAMPLE     2'h1
`define BMSD_ST_DONE       2'h2
// synchroniser settle cycles
`define BMSD_SETTLE        2'h2
`endif

// file: src/bmsd_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bus of pin levels
module bmsd_sync #(
	parameter W = 5
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// first stage feeds only the second
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // bmsd_sync
`default_nettype wire

// file: verification/bmsd_straps.sv
`timescale 1ns/1ps
`default_nettype none
// board strap resistors: driven levels, or pins left open
module bmsd_straps (
	input  wire logic [3:0] lv,
	input  wire logic       open,
	output wire logic [3:0] pins
);
	// open flash strap pulls up, unpulled ones drift to the inverse level
	assign pins = open ? {1'b1, ~lv[2:0]} : lv;
endmodule // bmsd_straps
`default_nettype wire

// file: verification/bmsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bmsd_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [2:0]  boot_mode,
	input wire logic [21:0] entry_addr,
	input wire logic        mode_valid,
	input wire logic        load_eeprom,
	input wire logic        load_uart,
	input wire logic        load_parallel,
	input wire logic        ext_fetch_allowed,
	input wire logic        boot_rom_enable,
	input wire logic [3:0]  strap_pullup_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// the edge where the decision lands
	sequence s_dec; !mode_valid ##1 mode_valid; endsequence
	valid_hold_a: assert property (mode_valid |=> mode_valid) else $error("valid dropped");
	mode_hold_a: assert property (mode_valid |=> $stable({boot_mode, entry_addr}))
		else $error("mode moved");
	dec_made_a: assert property (s_dec |-> boot_mode != 3'h0) else $error("no mode");
	flash_addr_a: assert property (mode_valid && boot_mode == 3'h1
		|-> entry_addr == 22'h3f7ff6) else $error("flash entry");
	ram_addr_a: assert property (mode_valid && boot_mode == 3'h4
		|-> entry_addr == 22'h3f8000) else $error("ram entry");
	otp_addr_a: assert property (mode_valid && boot_mode == 3'h5
		|-> entry_addr == 22'h3d7800) else $error("otp entry");
	no_fetch_a: assert property (mode_valid
		|-> ext_fetch_allowed == (load_eeprom | load_uart | load_parallel)) else $error("fetch");
	one_load_a: assert property (
		$onehot0({load_eeprom, load_uart, load_parallel})) else $error("loaders");
	pullup_fixed_a: assert property (strap_pullup_en == 4'h8) else $error("pullups");
	rom_off_a: assert property (s_dec |-> boot_rom_enable == (boot_mode != 3'h7))
		else $error("rom enable");
endmodule // bmsd_checker
bind bmsd_top bmsd_checker u_chk (.*);
`default_nettype wire

// file: verification/tb_boot_mode_strap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_boot_mode_strap_decoder;
	logic        clk = 0, rst = 1, microprocessor_mode_pin = 0, flt = 0;
	logic [3:0]  lv = 0;
	wire logic   strap_flash_select, strap_eeprom_select, strap_third, strap_fourth;
	wire logic   mode_valid, load_eeprom, load_uart, load_parallel;
	wire logic   ext_fetch_allowed, boot_rom_enable;
	wire logic [2:0]  boot_mode;
	wire logic [21:0] entry_addr;
	wire logic [3:0]  strap_pullup_en;
	logic [29:0] q[$];
	logic [29:0] e;
	logic [29:0] obs;
	logic [31:0] r = 32'h46e4;
	int          num_errors = 0, samples_checked = 0;
	bmsd_top DUT (.*);
	bmsd_straps PM (.lv(lv), .open(flt),
		.pins({strap_flash_select, strap_eeprom_select, strap_third, strap_fourth}));
	always #50 clk = ~clk;
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// {mode, entry, eeprom, uart, parallel, ext fetch, rom} from {mp pin, straps}
	function [29:0] ex(input [4:0] p);
		casez (p)
			5'b1????: ex = {3'h7, 22'h0, 5'h00};
			5'b01???: ex = {3'h1, 22'h3f7ff6, 5'h01}; // user branch sits here
			5'b001??: ex = {3'h2, 22'h0, 5'h13};
			5'b00011: ex = {3'h3, 22'h0, 5'h0b};
			5'b00010: ex = {3'h4, 22'h3f8000, 5'h01};
			5'b00001: ex = {3'h5, 22'h3d7800, 5'h01};
			default:  ex = {3'h6, 22'h0, 5'h07};
		endcase
	endfunction
	task chk(input [29:0] x, input [29:0] g);
		samples_checked++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask
	task chk_pu(input [3:0] x, input [3:0] g);
		samples_checked++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask
	task end_sim;
		$display("errors=%0d checked=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// watcher: each settled decision is held against the oldest note
	always @(negedge clk) if (mode_valid === 1'b1 && q.size() > 0) begin
		obs = {boot_mode, entry_addr, load_eeprom, load_uart, load_parallel, ext_fetch_allowed,
			boot_rom_enable};
		chk(q.pop_front(), obs);
		chk_pu(4'h8, strap_pullup_en);
	end
	// every strap pattern with and without mp pin, then one open board
	initial begin
		for (int i = 0; i < 33; i++) begin
			@(posedge clk);
			rst <= 1;
			{flt, microprocessor_mode_pin, lv} <= i[5:0];
			e = ex(i[5] ? 5'h08 : i[4:0]);
			repeat (10) @(posedge clk);
			q.push_back(e);
			rst <= 0;
			for (int k = 0; k < 20 && mode_valid !== 1'b1; k++) @(posedge clk);
			if (mode_valid !== 1'b1) num_errors++;
			r = lfsr(r);
			{microprocessor_mode_pin, lv} <= r[4:0];
			repeat (5) @(posedge clk);
			q.push_back(e);
			repeat (2) @(posedge clk);
		end
		end_sim;
	end
	// hang guard
	initial begin
		#300000;
		num_errors++;
		end_sim;
	end
endmodule // tb_boot_mode_strap_decoder
`default_nettype wire
